/* src/dic_pkg.sv */
// Purpose: Shared constants and types for the digital input capture block
// Assumes: 100 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes:   Register offsets are byte addresses of aligned words
package dic_pkg;

    // Clock and timing
    localparam int  CLK_PERIOD_NS   = 10;
    localparam int  TIMER_STEP_NS   = 10;
    localparam int  TIMER_STEP_CYC  = TIMER_STEP_NS / CLK_PERIOD_NS;
    localparam int  MAX_RATE_MSA    = 10;
    localparam int  MIN_PERIOD_NS   = 1000 / MAX_RATE_MSA;
    localparam int  MIN_PERIOD_CYC  = MIN_PERIOD_NS / CLK_PERIOD_NS;

    // Widths and depths
    localparam int  DIN_W           = 16;
    localparam int  FIFO_DEPTH      = 4096;
    localparam int  PTR_W           = 12;
    localparam int  CNT_W           = 22;
    localparam int  SRC_W           = 4;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] CMD_OFS     = 8'h04;
    localparam logic [7:0] PERIOD_OFS  = 8'h08;
    localparam logic [7:0] COUNT_OFS   = 8'h0C;
    localparam logic [7:0] PRETRIG_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS  = 8'h14;
    localparam logic [7:0] LEVEL_OFS   = 8'h18;

    // CTRL field positions
    localparam int  CTRL_ENABLE_BIT = 0;
    localparam int  CTRL_FINITE_BIT = 1;
    localparam int  CTRL_EXTCLK_BIT = 2;
    localparam int  CTRL_CLKOUT_BIT = 3;
    localparam int  CTRL_TRGOUT_BIT = 4;
    localparam int  CTRL_SRC_LSB    = 8;

    // CMD field positions (write one to act)
    localparam int  CMD_SOFT_BIT    = 0;
    localparam int  CMD_GLOBAL_BIT  = 1;
    localparam int  CMD_CLEAR_BIT   = 2;

    // Reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] PERIOD_RST  = 32'h0000_000A;
    localparam logic [CNT_W-1:0] COUNT_RST = 22'h00_0400;
    localparam logic [PTR_W:0]   PRE_RST   = 13'h0000;

    // Limits
    localparam logic [CNT_W-1:0] COUNT_MAX = 22'h20_0000;
    localparam logic [PTR_W:0]   PRE_MAX   = 13'h1000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Trigger source selection
    typedef enum logic [SRC_W-1:0] {
        SRC_SOFT   = 4'h0,
        SRC_EXT    = 4'h1,
        SRC_DIO0   = 4'h2,
        SRC_DIO1   = 4'h3,
        SRC_DI     = 4'h4,
        SRC_DO     = 4'h5,
        SRC_AO0    = 4'h6,
        SRC_AO1    = 4'h7,
        SRC_AO2    = 4'h8,
        SRC_AO3    = 4'h9
    } trig_src_type;

    // Capture sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_ARMED   = 4'b0010,
        ST_RUN     = 4'b0100,
        ST_DONE    = 4'b1000
    } cap_state_type;

endpackage : dic_pkg

/* src/fifo_if.sv */
// Purpose: Carrier between the sequencer and its sample memory
// Assumes: One write and one read port, same clock
// Notes:   Read data appear one cycle after the read strobe
`timescale 1ns/1ns
interface fifo_if;
    import dic_pkg::*;
    logic             wr_en;
    logic [PTR_W-1:0] wr_addr;
    logic [DIN_W-1:0] wr_data;
    logic             rd_en;
    logic [PTR_W-1:0] rd_addr;
    logic [DIN_W-1:0] rd_data;

    modport user (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  output rd_data);
endinterface : fifo_if

/* src/sample_mem.sv */
// Purpose: Sample memory behind the capture FIFO
// Assumes: Simple dual port, registered read
// Notes:   Write and read of the same word in one cycle return old data
`timescale 1ns/1ns
module sample_mem
    import dic_pkg::*;
(
    input  wire logic aclk,     // System clock
    fifo_if.mem       port      // Memory port
);
    logic [DIN_W-1:0] mem_q [FIFO_DEPTH];
    logic [DIN_W-1:0] rd_q;

    // Storage array has no reset, only its read register is used
    always_ff @(posedge aclk) begin
        if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
        if (port.rd_en) begin
            rd_q <= mem_q[port.rd_addr];
        end
    end

    assign port.rd_data = rd_q;
endmodule : sample_mem

/* src/trig_edge.sv */
// Purpose: Rising edge detector for trigger and clock inputs
// Assumes: Inputs synchronous to aclk
// Notes:   Pulse is one cycle, combinational, in the same cycle as the input rise
`timescale 1ns/1ns
module trig_edge
    import dic_pkg::*;
#(
    parameter int N = 9
) (
    input  wire logic         aclk,    // System clock
    input  wire logic         aresetn, // Sync reset, active low
    input  wire logic [N-1:0] level,   // Input levels
    output logic      [N-1:0] rise     // Rising edge pulses
);
    logic [N-1:0] prev_q;

    // Reset to all ones so a line already high gives no false edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= '1;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
endmodule : trig_edge

/* src/digital_input_capture_sequencer.sv */
// Purpose: Hardware-timed digital input capture with pre-trigger history
// Assumes: AXI4-Lite slave, host drains samples over a valid/ready stream
// Notes:   Notes on behaviour below list what the block provides
//
// Notes on behaviour
// - Continuous and finite modes, both strobed by a hardware sample clock.
// - Continuous mode samples at fixed rate and streams FIFO without pause.
// - Finite mode takes exactly the programmed count then halts itself.
// - All inputs sampled in parallel on one edge, up to 10 MSa/s.
// - Internal timer is default sample clock; software may pick another.
// - Timer period in 10 ns steps, never faster than device maximum.
// - External clock edges used directly as strobes, no division.
// - Timer output may be routed to the sample clock output pin.
// - Default trigger is soft command; global soft command also accepted.
// - External trigger fires on a rising edge.
// - Trigger event may be driven onto the external trigger output.
// - DIO edge lines trigger on rising edge when configured as inputs.
// - Sibling function triggers may be chosen as capture trigger.
// - Software clear returns trigger status to untriggered.
// - Pre-trigger history lives in FIFO, depth never above 4k.
// - Zero pre-trigger depth discards all samples before trigger.
// - Nonzero depth N keeps rolling latest N, evicting oldest.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module digital_input_capture_sequencer
    import dic_pkg::*;
(
    input  wire logic             aclk,          // 100 MHz clock
    input  wire logic             aresetn,       // Sync reset, active low
    input  wire logic [7:0]       s_axi_awaddr,  // Write address
    input  wire logic             s_axi_awvalid, // Write address valid
    output logic                  s_axi_awready, // Write address ready
    input  wire logic [31:0]      s_axi_wdata,   // Write data
    input  wire logic [3:0]       s_axi_wstrb,   // Write strobes
    input  wire logic             s_axi_wvalid,  // Write data valid
    output logic                  s_axi_wready,  // Write data ready
    output logic [1:0]            s_axi_bresp,   // Write response
    output logic                  s_axi_bvalid,  // Write response valid
    input  wire logic             s_axi_bready,  // Write response ready
    input  wire logic [7:0]       s_axi_araddr,  // Read address
    input  wire logic             s_axi_arvalid, // Read address valid
    output logic                  s_axi_arready, // Read address ready
    output logic [31:0]           s_axi_rdata,   // Read data
    output logic [1:0]            s_axi_rresp,   // Read response
    output logic                  s_axi_rvalid,  // Read data valid
    input  wire logic             s_axi_rready,  // Read data ready
    input  wire logic [DIN_W-1:0] din,           // Digital inputs
    input  wire logic             ext_clk_in,    // External sample clock
    output logic                  ext_clk_out,   // Sample clock output pin
    input  wire logic             ext_trig_in,   // External trigger input
    output logic                  ext_trig_out,  // Trigger output pin
    input  wire logic [1:0]       dio_in,        // DIO edge trigger pins
    input  wire logic [1:0]       dio_is_input,  // DIO direction is input
    input  wire logic [5:0]       sibling_trig,  // DI,DO,AO0..AO3 triggers
    output logic [DIN_W-1:0]      m_tdata,       // Sample stream data
    output logic                  m_tvalid,      // Sample stream valid
    input  wire logic             m_tready,      // Sample stream ready
    output logic                  overflow       // Sample lost, sticky
);
    typedef struct packed {
        logic                 aw_got;
        logic                 w_got;
        logic [7:0]           awaddr;
        logic [31:0]          wdata;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [1:0]           rresp;
        logic [31:0]          rdata;
        logic [31:0]          ctrl;
        logic [31:0]          period;
        logic [CNT_W-1:0]     count;
        logic [PTR_W:0]       pre;
        cap_state_type        state;
        logic                 triggered;
        logic                 overflow;
        logic [31:0]          tmr;
        logic                 tmr_tick;
        logic [PTR_W-1:0]     wr_ptr;
        logic [PTR_W-1:0]     rd_ptr;
        logic [PTR_W:0]       level;
        logic [CNT_W-1:0]     taken;
        logic                 rd_pend;
        logic                 out_valid;
        logic [DIN_W-1:0]     out_data;
        logic                 trig_out;
    } state_type;

    state_type q, d;
    fifo_if    fif ();
    logic [9:0] rise;
    logic       trig_hit;
    logic       strobe;
    logic       pushing;
    logic       popping;
    logic       evict;
    logic       out_take;

    sample_mem u_mem (
        .aclk (aclk),
        .port (fif.mem)
    );

    trig_edge #(.N(10)) u_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   ({sibling_trig, dio_in, ext_trig_in, ext_clk_in}),
        .rise    (rise)
    );

    // Byte-lane merge of a write into an old register value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = val[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // Trigger selection; the global command counts as a soft trigger only when source 0 is selected
    always_comb begin
        unique case (trig_src_type'(q.ctrl[CTRL_SRC_LSB +: SRC_W]))
            SRC_EXT:  trig_hit = rise[1];
            SRC_DIO0: trig_hit = rise[2] & dio_is_input[0];
            SRC_DIO1: trig_hit = rise[3] & dio_is_input[1];
            SRC_DI:   trig_hit = rise[4];
            SRC_DO:   trig_hit = rise[5];
            SRC_AO0:  trig_hit = rise[6];
            SRC_AO1:  trig_hit = rise[7];
            SRC_AO2:  trig_hit = rise[8];
            SRC_AO3:  trig_hit = rise[9];
            default:  trig_hit = 1'b0;
        endcase
    end

    // Sample strobe: timer tick or external clock edge, no division
    // hardware strobe, external edge direct
    assign strobe = q.ctrl[CTRL_EXTCLK_BIT] ? rise[0] : q.tmr_tick;

    // Stream output handshake and FIFO movement
    assign out_take = q.out_valid & m_tready;
    assign popping  = (q.level != '0) && !q.rd_pend && q.triggered
                      && (!q.out_valid || out_take);
    assign fif.rd_en   = popping;
    assign fif.rd_addr = q.rd_ptr;
    assign fif.wr_data = din;
    assign fif.wr_addr = q.wr_ptr;
    assign fif.wr_en   = pushing;

    // Capture sequencer and FIFO bookkeeping
    always_comb begin
        d        = q;
        pushing  = 1'b0;
        evict    = 1'b0;
        d.tmr_tick = 1'b0;

        // timer counts 10 ns steps, clamped to the fastest rate
        if (q.state != ST_IDLE) begin
            if (q.tmr + 32'(TIMER_STEP_CYC) >= q.period) begin
                d.tmr = '0;
                d.tmr_tick = 1'b1;
            end else begin
                d.tmr = q.tmr + 32'(TIMER_STEP_CYC);
            end
        end else begin
            d.tmr = '0;
        end

        unique case (q.state)
            ST_IDLE: begin
                if (q.ctrl[CTRL_ENABLE_BIT]) d.state = ST_ARMED;
            end
            ST_ARMED: begin
                // zero depth stores nothing before trigger
                if (strobe && q.pre != '0) begin
                    pushing = 1'b1;
                    evict   = (q.level >= q.pre);
                end
            end
            ST_RUN: begin
                if (strobe) begin
                    if (q.level != (PTR_W+1)'(FIFO_DEPTH)) begin
                        pushing = 1'b1;
                        d.taken = q.taken + 1'b1;
                    end
                end
                // finite mode stops itself at the count
                if (q.ctrl[CTRL_FINITE_BIT] && strobe
                    && q.taken + 1'b1 >= q.count) begin
                    d.state = ST_DONE;
                end
            end
            ST_DONE: ;
        endcase
        if (!q.ctrl[CTRL_ENABLE_BIT]) d.state = ST_IDLE;

        // Pointer and level update
        if (pushing) d.wr_ptr = q.wr_ptr + 1'b1;
        if (popping || evict) d.rd_ptr = q.rd_ptr + 1'b1;
        d.level = q.level + (PTR_W+1)'(pushing)
                  - (PTR_W+1)'(popping || evict);
        d.rd_pend = popping;
        if (q.rd_pend) begin
            d.out_valid = 1'b1;
            d.out_data  = fif.rd_data;
        end else if (out_take) begin
            d.out_valid = 1'b0;
        end

        // trigger event pulsed on output pin
        d.trig_out = 1'b0;
        if (q.state == ST_ARMED && !q.triggered) begin
            if (trig_hit) begin
                d.triggered = 1'b1;
                d.trig_out  = 1'b1;
                d.state     = ST_RUN;
            end
        end

        // AXI write channel: address and data in either order
        if (s_axi_awvalid && !q.aw_got) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_got) begin
            d.w_got = 1'b1;
            d.wdata = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = RESP_OKAY;
            unique case (q.awaddr)
                CTRL_OFS:   d.ctrl = q.wdata;
                CMD_OFS: begin
                    if (q.wdata[CMD_CLEAR_BIT]) begin
                        d.triggered = 1'b0;
                        d.taken     = '0;
                        d.level     = '0;
                        d.rd_ptr    = q.wr_ptr;
                        d.out_valid = 1'b0;
                        d.rd_pend   = 1'b0;
                        if (q.state != ST_IDLE) d.state = ST_ARMED;
                    end else if ((q.wdata[CMD_SOFT_BIT]
                                  || q.wdata[CMD_GLOBAL_BIT])
                                 && q.state == ST_ARMED && !q.triggered
                                 && q.ctrl[CTRL_SRC_LSB +: SRC_W] == '0)
                    begin
                        d.triggered = 1'b1;
                        d.trig_out  = 1'b1;
                        d.state     = ST_RUN;
                    end
                end
                PERIOD_OFS: d.period = (q.wdata < 32'(MIN_PERIOD_CYC))
                                       ? 32'(MIN_PERIOD_CYC) : q.wdata;
                COUNT_OFS: begin
                    if (q.wdata > 32'(COUNT_MAX) || q.wdata == '0) begin
                        d.bresp = RESP_SLVERR;
                    end else begin
                        d.count = q.wdata[CNT_W-1:0];
                    end
                end
                PRETRIG_OFS: begin
                    if (q.wdata > 32'(PRE_MAX)) begin
                        d.bresp = RESP_SLVERR;
                    end else begin
                        d.pre = q.wdata[PTR_W:0];
                    end
                end
                default:    d.bresp = RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;

        // AXI read channel, one read at a time
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                CTRL_OFS:    d.rdata = q.ctrl;
                CMD_OFS:     d.rdata = 32'h0000_0000;
                PERIOD_OFS:  d.rdata = q.period;
                COUNT_OFS:   d.rdata = 32'(q.count);
                PRETRIG_OFS: d.rdata = 32'(q.pre);
                STATUS_OFS:  d.rdata = {26'h000_0000, q.overflow,
                                        q.triggered, q.state};
                LEVEL_OFS:   d.rdata = 32'(q.level);
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = RESP_SLVERR;
                end
            endcase
            if (s_axi_araddr == STATUS_OFS) d.overflow = 1'b0;
        end
        if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
        // Set wins over read-clear of the overflow flag
        if (q.state == ST_RUN && strobe
            && q.level == (PTR_W+1)'(FIFO_DEPTH)) d.overflow = 1'b1;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q        <= '0;
            q.ctrl   <= CTRL_RST;
            q.period <= PERIOD_RST;
            q.count  <= COUNT_RST;
            q.pre    <= PRE_RST;
            q.state  <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // Bus and pin outputs
    assign s_axi_awready = !q.aw_got;
    assign s_axi_wready  = !q.w_got;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rdata   = q.rdata;
    // timer tick drives clock output when enabled
    assign ext_clk_out   = q.ctrl[CTRL_CLKOUT_BIT] & q.tmr_tick;
    assign ext_trig_out  = q.ctrl[CTRL_TRGOUT_BIT] & q.trig_out;
    assign m_tdata       = q.out_data;
    assign m_tvalid      = q.out_valid;
    assign overflow      = q.overflow;
endmodule : digital_input_capture_sequencer

/* test/dic_sva.sv */
// Purpose: Port-level checks of the capture block
// Assumes: Bound to the capture block top module
// Notes:   Refusal checks fire only when both write channels go at once
`timescale 1ns/1ns
module dic_sva
    import dic_pkg::*;
(
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic s_axi_rready, m_tvalid, m_tready, ext_clk_out,
    input wire logic ext_trig_out, overflow,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [DIN_W-1:0] m_tdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data taken at the same edge
    sequence wr_both(a);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == a;
    endsequence
    sequence slv_err;
        ##[0:2] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endsequence
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid) else $error("rvalid dropped");
    a_stream_hold: assert property (m_tvalid && !m_tready |=>
        m_tvalid && $stable(m_tdata)) else $error("stream word dropped");
    a_clk_spacing: assert property (ext_clk_out |=>
        !ext_clk_out [*8]) else $error("sample clock too fast");
    a_trig_pulse: assert property (ext_trig_out |=>
        !ext_trig_out) else $error("trigger out not a pulse");
    a_ovf_sticky: assert property (overflow && !s_axi_arvalid
        && !s_axi_rvalid |=> overflow) else $error("overflow lost");
    a_count_refused: assert property (wr_both(COUNT_OFS) ##0
        s_axi_wdata > 32'h0020_0000 |=> slv_err) else $error("count kept");
    a_pre_refused: assert property (wr_both(PRETRIG_OFS) ##0
        s_axi_wdata > 32'h0000_1000 |=> slv_err) else $error("depth kept");
endmodule : dic_sva

bind digital_input_capture_sequencer dic_sva chk (.*);

/* test/host_sink.sv */
// Purpose: Host side that drains the sample stream
// Assumes: Stall input slows it to one word in four
// Notes:   Received words are kept for the bench to inspect
`timescale 1ns/1ns
module host_sink
    import dic_pkg::*;
(
    input  wire logic             aclk,     // System clock
    input  wire logic             aresetn,  // Sync reset, active low
    input  wire logic [DIN_W-1:0] m_tdata,  // Sample word
    input  wire logic             m_tvalid, // Sample valid
    input  wire logic             stall,    // Slow draining
    output logic                  m_tready  // Ready to take
);
    logic [DIN_W-1:0] got [$];
    logic [1:0]       ph_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            m_tready <= 1'b0;
            ph_q     <= 2'h0;
        end else begin
            ph_q     <= ph_q + 2'h1;
            m_tready <= !stall || ph_q == 2'h0;
            if (m_tvalid && m_tready) got.push_back(m_tdata);
        end
    end
endmodule : host_sink

/* test/digital_input_capture_sequencer_tb.sv */
// Purpose: Self-checking bench of the capture block
// Assumes: Registers reached over AXI4-Lite, host drains the stream
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ns
module digital_input_capture_sequencer_tb;
    import dic_pkg::*;
    localparam logic [7:0]  OA [6] = '{CTRL_OFS, PERIOD_OFS, COUNT_OFS,
        PRETRIG_OFS, STATUS_OFS, LEVEL_OFS};
    localparam logic [31:0] EV [6] = '{CTRL_RST, PERIOD_RST,
        32'(COUNT_RST), 32'(PRE_RST), 32'(ST_IDLE), 32'h0};
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, ext_clk_in = 0, ext_trig_in = 0;
    logic stall = 0, awready, wready, bvalid, arready, rvalid, tvalid;
    logic tready, clk_out, trig_out, ovf;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp, dio_in = 0, dio_dir = 3;
    logic [5:0] sib = 0;
    logic [DIN_W-1:0] din = 16'hA5C3, tdata;
    int miscompares = 0, compares = 0;
    always #5 aclk = ~aclk;
    digital_input_capture_sequencer uut (.aclk, .aresetn,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .din, .ext_clk_in, .ext_clk_out(clk_out),
        .ext_trig_in, .ext_trig_out(trig_out), .dio_in,
        .dio_is_input(dio_dir), .sibling_trig(sib), .m_tdata(tdata),
        .m_tvalid(tvalid), .m_tready(tready), .overflow(ovf));
    host_sink host (.aclk, .aresetn, .m_tdata(tdata), .m_tvalid(tvalid),
        .stall, .m_tready(tready));
    task automatic give_verdict;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask : wt
    // Both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(e));
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
    task automatic trg_flag(input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(STATUS_OFS, d, r);
        chk(32'(d[4]), e);
    endtask : trg_flag
    task automatic rearm;
        wr(CTRL_OFS, 32'h0, RESP_OKAY);
        wr(CMD_OFS, 32'h4, RESP_OKAY);
        host.got.delete();
    endtask : rearm
    task automatic t_reset_refuse;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 6; i++) begin
            rd(OA[i], d, r);
            chk(d, EV[i]);
        end
        rd(8'h1C, d, r);
        chk({d[29:0], r}, 32'(RESP_SLVERR));
        wr(COUNT_OFS, 32'h0020_0001, RESP_SLVERR);
        wr(COUNT_OFS, 32'h0020_0000, RESP_OKAY);
        wr(PRETRIG_OFS, 32'h0000_1001, RESP_SLVERR);
        wr(PRETRIG_OFS, 32'h0000_1000, RESP_OKAY);
        wr(PRETRIG_OFS, 32'h0, RESP_OKAY);
    endtask : t_reset_refuse
    // Finite soft capture, slow host, both outputs routed
    task automatic t_soft_finite;
        stall <= 1'b1;
        wr(COUNT_OFS, 32'h4, RESP_OKAY);
        wr(CTRL_OFS, 32'h1B, RESP_OKAY);
        wt(30);
        wr(CMD_OFS, 32'h1, RESP_OKAY);
        wt(300);
        chk(host.got.size(), 32'h4);
        foreach (host.got[i]) chk(32'(host.got[i]), 32'(din));
        stall <= 1'b0;
        rearm();
    endtask : t_soft_finite
    // Three history words then two; a second edge is ignored
    task automatic t_pretrig_ext;
        wr(PRETRIG_OFS, 32'h3, RESP_OKAY);
        wr(COUNT_OFS, 32'h2, RESP_OKAY);
        wr(CTRL_OFS, 32'h103, RESP_OKAY);
        wt(100);
        ext_trig_in <= 1'b1;
        wt(4);
        ext_trig_in <= 1'b0;
        wt(4);
        ext_trig_in <= 1'b1;
        wt(300);
        chk(host.got.size(), 32'h5);
        trg_flag(32'h1);
        wr(CMD_OFS, 32'h4, RESP_OKAY);
        trg_flag(32'h0);
        ext_trig_in <= 1'b0;
        wr(PRETRIG_OFS, 32'h0, RESP_OKAY);
        rearm();
    endtask : t_pretrig_ext
    // Source 0 by global command, the rest by their lines
    task automatic t_sources;
        wr(COUNT_OFS, 32'h1, RESP_OKAY);
        dio_dir <= 2'h2;
        wr(CTRL_OFS, 32'h203, RESP_OKAY);
        dio_in <= 2'h1;
        wt(3);
        {dio_in, dio_dir} <= 4'h3;
        trg_flag(32'h0);
        rearm();
        for (int s = 0; s < 10; s++) begin
            wr(CTRL_OFS, 32'h3 | 32'(s << 8), RESP_OKAY);
            if (s == 0) wr(CMD_OFS, 32'h2, RESP_OKAY);
            else begin
                {sib, dio_in, ext_trig_in} <= 9'h1 << (s - 1);
                wt(3);
                {sib, dio_in, ext_trig_in} <= 9'h0;
            end
            wt(20);
            trg_flag(32'h1);
            rearm();
        end
    endtask : t_sources
    task automatic t_ext_clock;
        wr(CTRL_OFS, 32'h5, RESP_OKAY);
        wr(CMD_OFS, 32'h1, RESP_OKAY);
        wt(20);
        repeat (3) begin
            ext_clk_in <= 1'b1;
            wt(5);
            ext_clk_in <= 1'b0;
            wt(10);
        end
        wt(40);
        chk(host.got.size(), 32'h3);
        chk(32'(ovf), 32'h0);
        rearm();
    endtask : t_ext_clock
    // Hang guard, far past what the tests need
    initial begin
        #300000;
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_refuse();
        t_soft_finite();
        t_pretrig_ext();
        t_sources();
        t_ext_clock();
        give_verdict();
    end
endmodule : digital_input_capture_sequencer_tb
